// ==== gpio_ports.sv ====
// General purpose I/O ports zero, two and five with their register file
`timescale 1ns/1ps

`include "gpio_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module gpio_ports #(
  parameter int PORT_ZERO_PINS = `PORT_ZERO_PIN_COUNT,
  parameter int PORT_TWO_PINS = `PORT_TWO_PIN_COUNT,
  parameter int PORT_FIVE_PINS = `PORT_FIVE_PIN_COUNT
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Register port
  input wire gpio_pkg::reg_addr_t addr_i,
  input wire gpio_pkg::reg_byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output gpio_pkg::reg_byte_t rdata_o,
  // Port zero pins
  input wire logic [PORT_ZERO_PINS-1:0] port_zero_in_i,
  output logic [PORT_ZERO_PINS-1:0] port_zero_out_o,
  output logic [PORT_ZERO_PINS-1:0] port_zero_oe_o,
  output logic [PORT_ZERO_PINS-1:0] port_zero_pullup_o,
  // Port two pins
  input wire logic [PORT_TWO_PINS-1:0] port_two_in_i,
  output logic [PORT_TWO_PINS-1:0] port_two_out_o,
  output logic [PORT_TWO_PINS-1:0] port_two_oe_o,
  output logic [PORT_TWO_PINS-1:0] port_two_pullup_o,
  // Port five pins
  input wire logic [PORT_FIVE_PINS-1:0] port_five_in_i,
  output logic [PORT_FIVE_PINS-1:0] port_five_out_o,
  output logic [PORT_FIVE_PINS-1:0] port_five_oe_o,
  output logic [PORT_FIVE_PINS-1:0] port_five_pullup_o
);

  import gpio_pkg::*;

  localparam int TOTAL_PINS = PORT_ZERO_PINS + PORT_TWO_PINS + PORT_FIVE_PINS;

  //////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Ones in the low positions that carry a real pin
  function automatic reg_byte_t pin_mask(input int pins);
    reg_byte_t m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = (i < pins);
    end
    return m;
  endfunction : pin_mask

  // Kind of register behind an address
  function automatic access_kind_t decode_kind(input reg_addr_t a);
    access_kind_t k;
    k = ACC_NONE;
    case (a)
      `PORT_ZERO_DIRECTION_ADDR,
      `PORT_TWO_DIRECTION_ADDR,
      `PORT_FIVE_DIRECTION_ADDR: k = ACC_DIR;
      `PORT_ZERO_DATA_ADDR,
      `PORT_TWO_DATA_ADDR,
      `PORT_FIVE_DATA_ADDR: k = ACC_DATA;
      `PORT_ZERO_PULLUP_ADDR,
      `PORT_TWO_PULLUP_ADDR,
      `PORT_FIVE_PULLUP_ADDR: k = ACC_PULL;
      `PORT_ZERO_DIR_SET_ADDR,
      `PORT_TWO_DIR_SET_ADDR,
      `PORT_FIVE_DIR_SET_ADDR: k = ACC_DIR_SET;
      `PORT_ZERO_DIR_CLR_ADDR,
      `PORT_TWO_DIR_CLR_ADDR,
      `PORT_FIVE_DIR_CLR_ADDR: k = ACC_DIR_CLR;
      default: k = ACC_NONE;
    endcase
    return k;
  endfunction : decode_kind

  // Port behind an address; unmapped addresses fall to zero and are gated by kind
  function automatic port_sel_t decode_port(input reg_addr_t a);
    port_sel_t p;
    p = SEL_ZERO;
    case (a)
      `PORT_TWO_DIRECTION_ADDR,
      `PORT_TWO_DATA_ADDR,
      `PORT_TWO_PULLUP_ADDR,
      `PORT_TWO_DIR_SET_ADDR,
      `PORT_TWO_DIR_CLR_ADDR: p = SEL_TWO;
      `PORT_FIVE_DIRECTION_ADDR,
      `PORT_FIVE_DATA_ADDR,
      `PORT_FIVE_PULLUP_ADDR,
      `PORT_FIVE_DIR_SET_ADDR,
      `PORT_FIVE_DIR_CLR_ADDR: p = SEL_FIVE;
      default: p = SEL_ZERO;
    endcase
    return p;
  endfunction : decode_port

  // Pick one of three bytes by port
  function automatic reg_byte_t pick(input reg_byte_t b0, input reg_byte_t b1,
                                     input reg_byte_t b2, input port_sel_t p);
    reg_byte_t r;
    r = 8'h00;
    case (p)
      SEL_ZERO: r = b0;
      SEL_TWO: r = b1;
      SEL_FIVE: r = b2;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : pick

  // Next value of a register for one write
  function automatic reg_byte_t dir_update(input reg_byte_t cur, input reg_byte_t wd,
                                           input access_kind_t k);
    reg_byte_t r;
    r = cur;
    case (k)
      ACC_DIR: r = wd;
      ACC_DIR_SET: r = cur | wd;
      ACC_DIR_CLR: r = cur & ~wd;
      default: r = cur;
    endcase
    return r;
  endfunction : dir_update

  //////////////////////////////////////////////////////////////////////////////
  // Pin level synchronisation

  logic [TOTAL_PINS-1:0] pins_sync;

  // One synchroniser for all pins keeps the three ports aligned in time
  gpio_pin_sync #(
    .WIDTH(TOTAL_PINS)
  ) u_pin_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .async_i({port_five_in_i, port_two_in_i, port_zero_in_i}),
    .sync_o(pins_sync)
  );

  reg_byte_t level_zero;
  reg_byte_t level_two;
  reg_byte_t level_five;

  // Spread synchronised levels back into bytes, unused bits zero
  always_comb begin
    level_zero = 8'h00;
    level_two = 8'h00;
    level_five = 8'h00;
    level_zero[PORT_ZERO_PINS-1:0] = pins_sync[PORT_ZERO_PINS-1:0];
    level_two[PORT_TWO_PINS-1:0] = pins_sync[PORT_ZERO_PINS +: PORT_TWO_PINS];
    level_five[PORT_FIVE_PINS-1:0] =
      pins_sync[PORT_ZERO_PINS + PORT_TWO_PINS +: PORT_FIVE_PINS];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  localparam reg_byte_t MASK_ZERO = pin_mask(PORT_ZERO_PINS);
  localparam reg_byte_t MASK_TWO = pin_mask(PORT_TWO_PINS);
  localparam reg_byte_t MASK_FIVE = pin_mask(PORT_FIVE_PINS);

  // Decode is shared by reads and writes
  wire access_kind_t acc_kind = decode_kind(addr_i);
  wire port_sel_t acc_port = decode_port(addr_i);
  wire reg_byte_t acc_mask = pick(MASK_ZERO, MASK_TWO, MASK_FIVE, acc_port);
  wire reg_byte_t wdata_masked = wdata_i & acc_mask;
  wire wr_zero = wr_i && (acc_port == SEL_ZERO);
  wire wr_two = wr_i && (acc_port == SEL_TWO);
  wire wr_five = wr_i && (acc_port == SEL_FIVE);

  //////////////////////////////////////////////////////////////////////////////
  // Direction registers

  reg_byte_t dir_zero_reg;
  reg_byte_t dir_two_reg;
  reg_byte_t dir_five_reg;

  // Whole byte writes and bit set or clear share one path
  wire access_kind_t k_none = ACC_NONE;
  wire reg_byte_t dir_zero_next = dir_update(dir_zero_reg, wdata_masked,
                                             wr_zero ? acc_kind : k_none);
  wire reg_byte_t dir_two_next = dir_update(dir_two_reg, wdata_masked,
                                            wr_two ? acc_kind : k_none);
  wire reg_byte_t dir_five_next = dir_update(dir_five_reg, wdata_masked,
                                             wr_five ? acc_kind : k_none);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dir_zero_reg <= `DIRECTION_RESET;
      dir_two_reg <= `DIRECTION_RESET;
      dir_five_reg <= `DIRECTION_RESET;
    end else begin
      dir_zero_reg <= dir_zero_next;
      dir_two_reg <= dir_two_next;
      dir_five_reg <= dir_five_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output data latches and pull-up registers

  reg_byte_t data_zero_reg;
  reg_byte_t data_two_reg;
  reg_byte_t data_five_reg;
  reg_byte_t pull_zero_reg;
  reg_byte_t pull_two_reg;
  reg_byte_t pull_five_reg;

  // Latches take writes even in input mode, so software can preload a level
  wire wr_data = wr_i && (acc_kind == ACC_DATA);
  wire wr_pull = wr_i && (acc_kind == ACC_PULL);
  wire reg_byte_t data_zero_next = (wr_data && wr_zero) ? wdata_masked : data_zero_reg;
  wire reg_byte_t data_two_next = (wr_data && wr_two) ? wdata_masked : data_two_reg;
  wire reg_byte_t data_five_next = (wr_data && wr_five) ? wdata_masked : data_five_reg;
  wire reg_byte_t pull_zero_next = (wr_pull && wr_zero) ? wdata_masked : pull_zero_reg;
  wire reg_byte_t pull_two_next = (wr_pull && wr_two) ? wdata_masked : pull_two_reg;
  wire reg_byte_t pull_five_next = (wr_pull && wr_five) ? wdata_masked : pull_five_reg;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_zero_reg <= `DATA_RESET;
      data_two_reg <= `DATA_RESET;
      data_five_reg <= `DATA_RESET;
    end else begin
      data_zero_reg <= data_zero_next;
      data_two_reg <= data_two_next;
      data_five_reg <= data_five_next;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pull_zero_reg <= `PULLUP_RESET;
      pull_two_reg <= `PULLUP_RESET;
      pull_five_reg <= `PULLUP_RESET;
    end else begin
      pull_zero_reg <= pull_zero_next;
      pull_two_reg <= pull_two_next;
      pull_five_reg <= pull_five_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path

  // Per bit: output pins return the latch, input pins the synchronised level
  wire reg_byte_t view_zero = (dir_zero_reg & data_zero_reg) | (~dir_zero_reg & level_zero);
  wire reg_byte_t view_two = (dir_two_reg & data_two_reg) | (~dir_two_reg & level_two);
  wire reg_byte_t view_five = (dir_five_reg & data_five_reg) | (~dir_five_reg & level_five);
  wire reg_byte_t dir_sel = pick(dir_zero_reg, dir_two_reg, dir_five_reg, acc_port);
  wire reg_byte_t view_sel = pick(view_zero, view_two, view_five, acc_port);

  reg_byte_t rd_value;

  // Pull-up and strobe addresses are write only and read as zero
  always_comb begin
    case (acc_kind)
      ACC_DIR: rd_value = dir_sel;
      ACC_DATA: rd_value = view_sel & acc_mask;
      ACC_PULL: rd_value = `READ_IDLE;
      default: rd_value = `READ_IDLE;
    endcase
  end

  reg_byte_t rdata_reg;
  wire reg_byte_t rdata_next = rd_i ? rd_value : `READ_IDLE;

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= `READ_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops

  assign rdata_o = rdata_reg;

  // Driver enable follows the direction bit, so inputs never drive
  assign port_zero_oe_o = dir_zero_reg[PORT_ZERO_PINS-1:0];
  assign port_two_oe_o = dir_two_reg[PORT_TWO_PINS-1:0];
  assign port_five_oe_o = dir_five_reg[PORT_FIVE_PINS-1:0];
  assign port_zero_out_o = data_zero_reg[PORT_ZERO_PINS-1:0];
  assign port_two_out_o = data_two_reg[PORT_TWO_PINS-1:0];
  assign port_five_out_o = data_five_reg[PORT_FIVE_PINS-1:0];
  // Pull-up follows its bit regardless of direction; software owns the choice
  assign port_zero_pullup_o = pull_zero_reg[PORT_ZERO_PINS-1:0];
  assign port_two_pullup_o = pull_two_reg[PORT_TWO_PINS-1:0];
  assign port_five_pullup_o = pull_five_reg[PORT_FIVE_PINS-1:0];

endmodule : gpio_ports

// ==== gpio_consts.svh ====
// Register offsets, reset values and pin counts of the general purpose I/O block
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// Direction registers
`define PORT_ZERO_DIRECTION_ADDR 8'hb8
`define PORT_TWO_DIRECTION_ADDR 8'hc1
`define PORT_FIVE_DIRECTION_ADDR 8'hc5

// Data registers
`define PORT_ZERO_DATA_ADDR 8'hd0
`define PORT_TWO_DATA_ADDR 8'hd1
`define PORT_FIVE_DATA_ADDR 8'hd5

// Pull-up registers, write only
`define PORT_ZERO_PULLUP_ADDR 8'he1
`define PORT_TWO_PULLUP_ADDR 8'he2
`define PORT_FIVE_PULLUP_ADDR 8'he5

// Direction bit set and bit clear strobes, one per port
`define PORT_ZERO_DIR_SET_ADDR 8'hf0
`define PORT_TWO_DIR_SET_ADDR 8'hf1
`define PORT_FIVE_DIR_SET_ADDR 8'hf2
`define PORT_ZERO_DIR_CLR_ADDR 8'hf4
`define PORT_TWO_DIR_CLR_ADDR 8'hf5
`define PORT_FIVE_DIR_CLR_ADDR 8'hf6

// Reset values
`define DIRECTION_RESET 8'h00
`define DATA_RESET 8'h00
`define PULLUP_RESET 8'h00
`define READ_IDLE 8'h00

// Pins per port
`define PORT_ZERO_PIN_COUNT 8
`define PORT_TWO_PIN_COUNT 2
`define PORT_FIVE_PIN_COUNT 5

`endif

// ==== gpio_pkg.sv ====
// Types shared by the general purpose I/O block
package gpio_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [7:0] reg_addr_t;

  // What a register address selects
  typedef enum logic [2:0] {
    ACC_NONE,
    ACC_DIR,
    ACC_DATA,
    ACC_PULL,
    ACC_DIR_SET,
    ACC_DIR_CLR
  } access_kind_t;

  // Which port an address belongs to
  typedef enum logic [1:0] {
    SEL_ZERO,
    SEL_TWO,
    SEL_FIVE
  } port_sel_t;

endpackage : gpio_pkg

// ==== gpio_pin_sync.sv ====
// Two flip-flop synchroniser for the asynchronous pin levels
`timescale 1ns/1ps

module gpio_pin_sync #(
  parameter int WIDTH = 15
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule : gpio_pin_sync

// ==== gpio_pin_model.sv ====
// Behavioural model of the circuitry that hangs on the pins of one port
`timescale 1ns/1ps
module gpio_pin_model #(
  parameter int W = 8
) (
  // Clock
  input wire logic clock_i,
  // Block side
  input wire logic [W-1:0] out_i,
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] pullup_i,
  // Outside drivers
  input wire logic [W-1:0] ext_en_i,
  input wire logic [W-1:0] ext_val_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] float_reg = '0;
  // A floating pin flips every cycle, so a stale level never passes as a match
  // Plain always, since the declaration already gives the register a start value
  always @(posedge clock_i) begin
    float_reg <= ~float_reg;
  end
  // Block driver first, then outside driver, then pull-up
  assign level_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i)
    | (~oe_i & ~ext_en_i & (pullup_i | float_reg));
endmodule : gpio_pin_model

// ==== gpio_ports_asserts.sv ====
// Concurrent checks on the register port and pin outputs of the I/O block
`timescale 1ns/1ps
`include "gpio_consts.svh"
module gpio_ports_asserts #(
  parameter int PORT_ZERO_PINS = 8,
  parameter int PORT_TWO_PINS = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Register port
  input wire gpio_pkg::reg_addr_t addr_i,
  input wire gpio_pkg::reg_byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire gpio_pkg::reg_byte_t rdata_o,
  // Pins
  input wire logic [PORT_ZERO_PINS-1:0] port_zero_out_o,
  input wire logic [PORT_ZERO_PINS-1:0] port_zero_oe_o,
  input wire logic [PORT_ZERO_PINS-1:0] port_zero_pullup_o,
  input wire logic [PORT_TWO_PINS-1:0] port_two_oe_o
);
  import gpio_pkg::*;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  dir_write_a: assert property (wr_i && addr_i == `PORT_ZERO_DIRECTION_ADDR |=>
    port_zero_oe_o == $past(wdata_i[PORT_ZERO_PINS-1:0])) else $error("direction write lost");
  dir_hold_a: assert property (!wr_i |=> $stable(port_zero_oe_o))
    else $error("direction changed without a write");
  dir_set_a: assert property (wr_i && addr_i == `PORT_ZERO_DIR_SET_ADDR |=>
    port_zero_oe_o == ($past(port_zero_oe_o) | $past(wdata_i[PORT_ZERO_PINS-1:0])))
    else $error("bit set wrong");
  dir_clr_a: assert property (wr_i && addr_i == `PORT_ZERO_DIR_CLR_ADDR |=>
    port_zero_oe_o == ($past(port_zero_oe_o) & ~$past(wdata_i[PORT_ZERO_PINS-1:0])))
    else $error("bit clear wrong");
  pull_write_a: assert property (wr_i && addr_i == `PORT_ZERO_PULLUP_ADDR |=>
    port_zero_pullup_o == $past(wdata_i[PORT_ZERO_PINS-1:0])) else $error("pull-up write lost");
  pull_hidden_a: assert property (rd_i && addr_i == `PORT_ZERO_PULLUP_ADDR |=>
    rdata_o == 8'h00) else $error("pull-up readable");
  data_out_a: assert property (wr_i && addr_i == `PORT_ZERO_DATA_ADDR |=>
    port_zero_out_o == $past(wdata_i[PORT_ZERO_PINS-1:0])) else $error("output latch wrong");
  unused_bits_a: assert property (rd_i && addr_i == `PORT_TWO_DIRECTION_ADDR |=>
    rdata_o[7:PORT_TWO_PINS] == '0 && rdata_o[PORT_TWO_PINS-1:0] == port_two_oe_o)
    else $error("unused bits not zero");
endmodule : gpio_ports_asserts

bind gpio_ports gpio_ports_asserts #(
  .PORT_ZERO_PINS(PORT_ZERO_PINS),
  .PORT_TWO_PINS(PORT_TWO_PINS)
) u_gpio_ports_asserts (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .port_zero_out_o(port_zero_out_o), .port_zero_oe_o(port_zero_oe_o),
  .port_zero_pullup_o(port_zero_pullup_o), .port_two_oe_o(port_two_oe_o));

// ==== gpio_ports_tb.sv ====
// Self-checking testbench of the I/O block with modelled pin circuitry
`timescale 1ns/1ps
`include "gpio_consts.svh"
module gpio_ports_tb;
  import gpio_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  reg_addr_t addr_i = 8'h00;
  reg_byte_t wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  reg_byte_t rdata_o;
  reg_byte_t rv;
  logic [7:0] z_out, z_oe, z_pu, z_pin;
  logic [1:0] t_out, t_oe, t_pu, t_pin;
  logic [4:0] f_out, f_oe, f_pu, f_pin;
  logic [7:0] ext_en = 8'hff;
  logic [7:0] ext_val = 8'h00;
  int fail_count = 0;
  int checks = 0;

  gpio_ports u_gpio_ports (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .port_zero_in_i(z_pin), .port_zero_out_o(z_out), .port_zero_oe_o(z_oe),
    .port_zero_pullup_o(z_pu), .port_two_in_i(t_pin), .port_two_out_o(t_out),
    .port_two_oe_o(t_oe), .port_two_pullup_o(t_pu), .port_five_in_i(f_pin),
    .port_five_out_o(f_out), .port_five_oe_o(f_oe), .port_five_pullup_o(f_pu));
  // One pin model per port; the outside drive is shared, sliced per port
  gpio_pin_model #(.W(8)) u_gpio_pin_model_zero (.clock_i(clock_i), .out_i(z_out),
    .oe_i(z_oe), .pullup_i(z_pu), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(z_pin));
  gpio_pin_model #(.W(2)) u_gpio_pin_model_two (.clock_i(clock_i), .out_i(t_out),
    .oe_i(t_oe), .pullup_i(t_pu), .ext_en_i(ext_en[1:0]), .ext_val_i(ext_val[1:0]),
    .level_o(t_pin));
  gpio_pin_model #(.W(5)) u_gpio_pin_model_five (.clock_i(clock_i), .out_i(f_out),
    .oe_i(f_oe), .pullup_i(f_pu), .ext_en_i(ext_en[4:0]), .ext_val_i(ext_val[4:0]),
    .level_o(f_pin));

  initial begin
    forever #4 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Strobes are launched and dropped by non-blocking assignment after an edge
  task automatic wr_reg(input reg_addr_t a, input reg_byte_t d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input string what, input reg_addr_t a, input reg_byte_t exp);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk(what, rdata_o, exp);
  endtask : rd_chk

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    reg_addr_t a[9] = '{`PORT_ZERO_DIRECTION_ADDR, `PORT_TWO_DIRECTION_ADDR,
      `PORT_FIVE_DIRECTION_ADDR, `PORT_ZERO_DATA_ADDR, `PORT_TWO_DATA_ADDR,
      `PORT_FIVE_DATA_ADDR, `PORT_ZERO_PULLUP_ADDR, `PORT_TWO_PULLUP_ADDR,
      `PORT_FIVE_PULLUP_ADDR};
    foreach (a[i]) rd_chk("reset value", a[i], 8'h00);
    chk("oe at reset", z_oe | z_pu | z_out, 8'h00);
  endtask : t_reset

  task automatic t_direction;
    wr_reg(`PORT_ZERO_DIRECTION_ADDR, 8'h0f);
    chk("zero oe", z_oe, 8'h0f);
    rd_chk("zero dir", `PORT_ZERO_DIRECTION_ADDR, 8'h0f);
    wr_reg(`PORT_TWO_DIRECTION_ADDR, 8'hff);
    chk("two oe", {6'h00, t_oe}, 8'h03);
    rd_chk("two dir", `PORT_TWO_DIRECTION_ADDR, 8'h03);
    wr_reg(`PORT_FIVE_DIRECTION_ADDR, 8'hff);
    rd_chk("five dir", `PORT_FIVE_DIRECTION_ADDR, 8'h1f);
    wr_reg(8'h40, 8'hff);
    rd_chk("unmapped", 8'h40, 8'h00);
  endtask : t_direction

  task automatic t_set_clear;
    wr_reg(`PORT_ZERO_DIR_SET_ADDR, 8'h80);
    chk("zero set", z_oe, 8'h8f);
    wr_reg(`PORT_ZERO_DIR_CLR_ADDR, 8'h01);
    chk("zero clr", z_oe, 8'h8e);
    wr_reg(`PORT_TWO_DIR_CLR_ADDR, 8'h01);
    chk("two clr", {6'h00, t_oe}, 8'h02);
    wr_reg(`PORT_FIVE_DIR_CLR_ADDR, 8'h0a);
    chk("five clr", {3'h0, f_oe}, 8'h15);
    rd_chk("set read", `PORT_ZERO_DIR_SET_ADDR, 8'h00);
  endtask : t_set_clear

  // Output bits give the latch, input bits the level driven from outside
  task automatic t_data;
    ext_val <= 8'h54;
    wr_reg(`PORT_ZERO_DATA_ADDR, 8'hff);
    chk("zero out", z_out, 8'hff);
    rd_chk("zero data", `PORT_ZERO_DATA_ADDR, 8'h8e | (8'h54 & ~8'h8e));
    wr_reg(`PORT_ZERO_DATA_ADDR, 8'h00);
    rd_chk("zero data low", `PORT_ZERO_DATA_ADDR, 8'h54 & ~8'h8e);
    wr_reg(`PORT_TWO_DATA_ADDR, 8'hff);
    chk("two out", {6'h00, t_out}, 8'h03);
    rd_chk("two data", `PORT_TWO_DATA_ADDR, 8'h02);
  endtask : t_data

  // Outside driver released: only the pull-ups hold the input pins high
  task automatic t_pullup;
    ext_en <= 8'h00;
    wr_reg(`PORT_FIVE_DIR_CLR_ADDR, 8'h1f);
    wr_reg(`PORT_FIVE_PULLUP_ADDR, 8'hff);
    chk("five pull", {3'h0, f_pu}, 8'h1f);
    rd_chk("five pull read", `PORT_FIVE_PULLUP_ADDR, 8'h00);
    repeat (2) @(posedge clock_i);
    rd_chk("five pulled", `PORT_FIVE_DATA_ADDR, 8'h1f);
    wr_reg(`PORT_ZERO_PULLUP_ADDR, 8'ha5);
    chk("zero pull", z_pu, 8'ha5);
    rd_chk("zero pull read", `PORT_ZERO_PULLUP_ADDR, 8'h00);
  endtask : t_pullup

  // Bit set on the small ports, port five latch beside pulled inputs, port two pull-ups
  task automatic t_small_ports;
    wr_reg(`PORT_FIVE_DIR_SET_ADDR, 8'h03);
    chk("five set", {3'h0, f_oe}, 8'h03);
    wr_reg(`PORT_FIVE_DATA_ADDR, 8'hff);
    chk("five out", {3'h0, f_out}, 8'h1f);
    wr_reg(`PORT_FIVE_DATA_ADDR, 8'h00);
    chk("five out low", {3'h0, f_out}, 8'h00);
    rd_chk("five mixed", `PORT_FIVE_DATA_ADDR, 8'h1c);
    @(posedge clock_i);
    #1;
    chk("read data drop", rdata_o, 8'h00);
    wr_reg(`PORT_TWO_DIR_SET_ADDR, 8'h01);
    chk("two set", {6'h00, t_oe}, 8'h03);
    wr_reg(`PORT_TWO_PULLUP_ADDR, 8'hff);
    chk("two pull", {6'h00, t_pu}, 8'h03);
    rd_chk("two pull read", `PORT_TWO_PULLUP_ADDR, 8'h00);
  endtask : t_small_ports

  task automatic tally_and_finish;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_reset();
    t_direction();
    t_set_clear();
    t_data();
    t_pullup();
    t_small_ports();
    tally_and_finish();
  end
endmodule : gpio_ports_tb
